/* File: rtl/long_math_pkg.sv */
// Shared constants and types for the 32-bit long math unit.
// Assumes one clock domain and an APB master that drives the register file.
package long_math_pkg;

  localparam int unsigned       DATA_W      = 32;
  localparam int unsigned       ADDR_W      = 8;
  localparam int unsigned       DIV_STEPS   = 32;
  localparam int unsigned       CHK_IDX_MAX = 15;
  localparam int unsigned       MERGE_SHIFT = 8;

  localparam logic [7:0]        OFF_CONTROL  = 8'h00;
  localparam logic [7:0]        OFF_OPERAND_A = 8'h04;
  localparam logic [7:0]        OFF_CONST_B  = 8'h08;
  localparam logic [7:0]        OFF_RESULT   = 8'h0c;
  localparam logic [7:0]        OFF_STATUS   = 8'h10;

  localparam int unsigned       CTRL_OP_LSB   = 0;
  localparam int unsigned       CTRL_EDGE_BIT = 8;
  localparam int unsigned       CTRL_WB_BIT   = 9;
  localparam int unsigned       CTRL_BCON_BIT = 10;

  localparam int unsigned       STAT_BUSY_BIT  = 0;
  localparam int unsigned       STAT_CHECK_BIT = 1;
  localparam int unsigned       STAT_DIVZ_BIT  = 2;
  localparam int unsigned       STAT_OVR_BIT   = 3;

  localparam logic [31:0]       OPERAND_A_RESET = 32'h0000_0000;
  localparam logic [31:0]       CONST_B_RESET   = 32'h0000_0000;
  localparam logic [31:0]       RESULT_RESET    = 32'h0000_0000;

  typedef enum logic [4:0] {
    OP_ADD   = 5'h00,
    OP_SUB   = 5'h01,
    OP_MUL   = 5'h02,
    OP_DIV   = 5'h03,
    OP_AND   = 5'h04,
    OP_OR    = 5'h05,
    OP_XOR   = 5'h06,
    OP_SHL   = 5'h07,
    OP_SHR   = 5'h08,
    OP_CHK   = 5'h09,
    OP_LSCF  = 5'h0a,
    OP_RSCF  = 5'h0b,
    OP_LSCL  = 5'h0c,
    OP_RSCL  = 5'h0d,
    OP_GET   = 5'h0e,
    OP_LOLIM = 5'h0f,
    OP_HILIM = 5'h10,
    OP_MERGE = 5'h11,
    OP_W2S   = 5'h12,
    OP_SET   = 5'h13
  } op_t;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_DIVIDE = 2'b01
  } phase_t;

  typedef struct packed {
    logic b_from_constant;
    logic write_back;
    logic edge_trigger_enable;
    op_t  op;
  } control_t;

  localparam control_t CTRL_RESET = '{b_from_constant: 1'b0, write_back: 1'b0,
                                      edge_trigger_enable: 1'b0, op: OP_ADD};

  typedef struct packed {
    logic overrun;
    logic div_zero;
    logic check_bit;
    logic busy;
  } status_t;

  typedef struct packed {
    control_t    ctrl;
    logic [31:0] operand_a;
    logic [31:0] const_b;
    logic [31:0] result;
    logic [31:0] rdata;
    logic        trig_prev;
    logic        check_bit;
    logic        div_zero;
    logic        overrun;
    logic        result_strobe;
    logic        wb_pending;
    phase_t      phase;
  } core_state_t;

  typedef struct packed {
    logic [31:0] rem;
    logic [31:0] quo;
    logic [31:0] dvs;
    logic [5:0]  count;
    logic        negate;
    logic        done;
  } div_state_t;

endpackage

/* File: rtl/long_divider.sv */
// Iterative signed divider, one quotient bit per clock, truncating toward zero.
// Assumes the caller never starts it with a zero divisor and waits for done.
`timescale 1ns/1ps
module long_divider (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [31:0] dividend,
  input  wire logic [31:0] divisor,
  output logic             busy,
  output logic             done,
  output logic [31:0]      quotient
);

  long_math_pkg::div_state_t s;
  long_math_pkg::div_state_t next_s;
  logic [32:0]               trial;
  logic [31:0]               mag_a;
  logic [31:0]               mag_b;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    mag_a = dividend[31] ? 32'(-dividend) : dividend;
    mag_b = divisor[31] ? 32'(-divisor) : divisor;
    trial = {s.rem, s.quo[31]} - {1'b0, s.dvs};
    if (start && s.count == 6'h00) begin
      next_s.rem = 32'h0000_0000;
      next_s.quo = mag_a;
      next_s.dvs = mag_b;
      next_s.negate = dividend[31] ^ divisor[31];
      next_s.count = 6'(long_math_pkg::DIV_STEPS);
    end else if (s.count != 6'h00) begin
      // Restoring step: keep the trial remainder only when it did not go negative.
      if (!trial[32]) begin
        next_s.rem = trial[31:0];
        next_s.quo = {s.quo[30:0], 1'b1};
      end else begin
        next_s.rem = {s.rem[30:0], s.quo[31]};
        next_s.quo = {s.quo[30:0], 1'b0};
      end
      next_s.count = s.count - 6'h01;
      if (s.count == 6'h01) begin
        next_s.done = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy     = (s.count != 6'h00);
  assign done     = s.done;
  // The minimum negative dividend over minus one wraps back to itself.
  assign quotient = s.negate ? 32'(-s.quo) : s.quo;

endmodule // long_divider

/* File: rtl/long_math_unit.sv */
// Long math unit: 32-bit signed operation on operand A and operand B, APB slave.
// Assumes scan_tick pulses once per controller scan and trigger_in is synchronous.
//
// Operation
// - Result is a 32-bit signed output.
// - Operation chosen by configuration selector.
// - Edge mode evaluates once per trigger rise.
// - Otherwise evaluate every scan cycle.
// - Write-back stores result into operand A.
// - Operand B may come from constant.
// - Add outputs A plus B.
// - Subtract outputs A minus B.
// - Multiply outputs A times B.
// - Divide outputs integer quotient A by B.
// - AND is bitwise across all bits.
// - OR is bitwise across all bits.
// - XOR is bitwise across all bits.
// - Shift left A by B places.
// - Shift right A by B places.
// - Bit check outputs A bit B, 0-15.
// - Low limit outputs larger of A, B.
// - High limit outputs smaller of A, B.
`timescale 1ns/1ps
module long_math_unit (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] operand_b,
  input  wire logic        trigger_in,
  input  wire logic        scan_tick,
  output logic [31:0]      long_result_out,
  output logic [31:0]      operand_a_out,
  output logic             result_strobe
);

  long_math_pkg::core_state_t s;
  long_math_pkg::core_state_t next_s;
  long_math_pkg::status_t     status;

  logic        addr_hit;
  logic        wr_access;
  logic        rd_setup;
  logic        eval_req;
  logic        trig_rise;
  logic [31:0] b_eff;
  logic [31:0] res;
  logic        res_ok;
  logic        res_chk;
  logic [63:0] product;
  logic [31:0] shl_val;
  logic [31:0] shr_val;
  logic        b_small;
  logic        div_start;
  logic        div_busy;
  logic        div_done;
  logic [31:0] div_quot;

  long_divider u_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (div_start),
    .dividend (s.operand_a),
    .divisor  (b_eff),
    .busy     (div_busy),
    .done     (div_done),
    .quotient (div_quot)
  );

  always_comb begin
    unique case (paddr)
      long_math_pkg::OFF_CONTROL,
      long_math_pkg::OFF_OPERAND_A,
      long_math_pkg::OFF_CONST_B,
      long_math_pkg::OFF_RESULT,
      long_math_pkg::OFF_STATUS: addr_hit = 1'b1;
      default:                   addr_hit = 1'b0;
    endcase
  end

  // No wait states: read data is captured in the setup cycle so it leaves a flip-flop.
  assign pready    = psel && penable;
  assign pslverr   = psel && penable && !addr_hit;
  assign wr_access = psel && penable && pwrite && addr_hit;
  assign rd_setup  = psel && !penable && !pwrite;

  assign status.busy      = (s.phase == long_math_pkg::PH_DIVIDE) || div_busy;
  assign status.check_bit = s.check_bit;
  assign status.div_zero  = s.div_zero;
  assign status.overrun   = s.overrun;

  // The trigger is sampled once per scan, so a rise is seen across two scans.
  assign trig_rise = scan_tick && trigger_in && !s.trig_prev;
  assign eval_req  = s.ctrl.edge_trigger_enable ? trig_rise : scan_tick;

  assign b_eff   = s.ctrl.b_from_constant ? s.const_b : operand_b;
  assign product = $signed(s.operand_a) * $signed(b_eff);
  assign b_small = (b_eff[31:5] == 27'h0);
  assign shl_val = b_small ? (s.operand_a << b_eff[4:0]) : 32'h0000_0000;
  assign shr_val = b_small ? (s.operand_a >> b_eff[4:0]) : 32'h0000_0000;

  // Combinational result for every single-cycle operation.
  always_comb begin
    res     = s.result;
    res_ok  = 1'b1;
    res_chk = s.check_bit;
    unique case (s.ctrl.op)
      long_math_pkg::OP_ADD: begin
        res = 32'(s.operand_a + b_eff);
      end
      long_math_pkg::OP_SUB: begin
        res = 32'(s.operand_a - b_eff);
      end
      long_math_pkg::OP_MUL: begin
        res = product[31:0];
      end
      long_math_pkg::OP_AND: begin
        res = s.operand_a & b_eff;
      end
      long_math_pkg::OP_OR: begin
        res = s.operand_a | b_eff;
      end
      long_math_pkg::OP_XOR: begin
        res = s.operand_a ^ b_eff;
      end
      long_math_pkg::OP_SHL: begin
        res = shl_val;
      end
      long_math_pkg::OP_SHR: begin
        res = shr_val;
      end
      long_math_pkg::OP_CHK: begin
        // An index outside 0 to 15 is refused rather than guessed at.
        if (b_eff <= 32'(long_math_pkg::CHK_IDX_MAX)) begin
          res_chk = s.operand_a[b_eff[3:0]];
          res     = {31'h0000_0000, s.operand_a[b_eff[3:0]]};
        end else begin
          res_ok = 1'b0;
        end
      end
      long_math_pkg::OP_LSCF: begin
        res_chk = s.operand_a[0];
        res     = shl_val;
      end
      long_math_pkg::OP_RSCF: begin
        res_chk = s.operand_a[0];
        res     = shr_val;
      end
      long_math_pkg::OP_LSCL: begin
        res_chk = s.operand_a[15];
        res     = shl_val;
      end
      long_math_pkg::OP_RSCL: begin
        res_chk = s.operand_a[15];
        res     = shr_val;
      end
      long_math_pkg::OP_LOLIM: begin
        res = ($signed(b_eff) > $signed(s.operand_a)) ? b_eff : s.operand_a;
      end
      long_math_pkg::OP_HILIM: begin
        res = ($signed(b_eff) < $signed(s.operand_a)) ? b_eff : s.operand_a;
      end
      long_math_pkg::OP_MERGE: begin
        res = 32'(s.operand_a + (b_eff << long_math_pkg::MERGE_SHIFT));
      end
      long_math_pkg::OP_W2S: begin
        res = {{16{s.operand_a[15]}}, s.operand_a[15:0]};
      end
      long_math_pkg::OP_DIV,
      long_math_pkg::OP_GET,
      long_math_pkg::OP_SET: begin
        // Division runs in the divider; block addressing is not part of this unit.
        res_ok = 1'b0;
      end
      default: begin
        res_ok = 1'b0;
      end
    endcase
  end

  assign div_start = eval_req && (s.phase == long_math_pkg::PH_IDLE) &&
                     (s.ctrl.op == long_math_pkg::OP_DIV) && (b_eff != 32'h0000_0000);

  always_comb begin
    next_s = s;
    next_s.result_strobe = 1'b0;

    if (scan_tick) begin
      next_s.trig_prev = trigger_in;
    end

    // Register reads are captured in the setup cycle.
    if (rd_setup) begin
      unique case (paddr)
        long_math_pkg::OFF_CONTROL: begin
          // Read back in the same bit positions that a write uses.
          next_s.rdata                                  = 32'h0000_0000;
          next_s.rdata[long_math_pkg::CTRL_OP_LSB +: 5] = s.ctrl.op;
          next_s.rdata[long_math_pkg::CTRL_EDGE_BIT]    = s.ctrl.edge_trigger_enable;
          next_s.rdata[long_math_pkg::CTRL_WB_BIT]      = s.ctrl.write_back;
          next_s.rdata[long_math_pkg::CTRL_BCON_BIT]    = s.ctrl.b_from_constant;
        end
        long_math_pkg::OFF_OPERAND_A: begin
          next_s.rdata = s.operand_a;
        end
        long_math_pkg::OFF_CONST_B: begin
          next_s.rdata = s.const_b;
        end
        long_math_pkg::OFF_RESULT: begin
          next_s.rdata = s.result;
        end
        long_math_pkg::OFF_STATUS: begin
          next_s.rdata = 32'(status);
        end
        default: begin
          next_s.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Software writes come first so that hardware updates below take priority.
    if (wr_access) begin
      unique case (paddr)
        long_math_pkg::OFF_CONTROL: begin
          next_s.ctrl.op                  = long_math_pkg::op_t'(pwdata[long_math_pkg::CTRL_OP_LSB +: 5]);
          next_s.ctrl.edge_trigger_enable = pwdata[long_math_pkg::CTRL_EDGE_BIT];
          next_s.ctrl.write_back          = pwdata[long_math_pkg::CTRL_WB_BIT];
          next_s.ctrl.b_from_constant     = pwdata[long_math_pkg::CTRL_BCON_BIT];
        end
        long_math_pkg::OFF_OPERAND_A: begin
          next_s.operand_a = pwdata;
        end
        long_math_pkg::OFF_CONST_B: begin
          next_s.const_b = pwdata;
        end
        long_math_pkg::OFF_STATUS: begin
          if (pwdata[long_math_pkg::STAT_DIVZ_BIT]) begin
            next_s.div_zero = 1'b0;
          end
          if (pwdata[long_math_pkg::STAT_OVR_BIT]) begin
            next_s.overrun = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    unique case (s.phase)
      long_math_pkg::PH_IDLE: begin
        if (eval_req) begin
          if (s.ctrl.op == long_math_pkg::OP_DIV) begin
            if (b_eff == 32'h0000_0000) begin
              next_s.div_zero = 1'b1;
            end else begin
              next_s.phase      = long_math_pkg::PH_DIVIDE;
              next_s.wb_pending = s.ctrl.write_back;
            end
          end else if (res_ok) begin
            next_s.result        = res;
            next_s.check_bit     = res_chk;
            next_s.result_strobe = 1'b1;
            if (s.ctrl.write_back) begin
              next_s.operand_a = res;
            end
          end
        end
      end
      long_math_pkg::PH_DIVIDE: begin
        // Scans that arrive while a quotient is still forming are dropped and flagged.
        if (eval_req) begin
          next_s.overrun = 1'b1;
        end
        if (div_done) begin
          next_s.result        = div_quot;
          next_s.result_strobe = 1'b1;
          next_s.phase         = long_math_pkg::PH_IDLE;
          if (s.wb_pending) begin
            next_s.operand_a = div_quot;
          end
        end
      end
      default: begin
        next_s.phase = long_math_pkg::PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s               <= '0;
      s.ctrl          <= long_math_pkg::CTRL_RESET;
      s.operand_a     <= long_math_pkg::OPERAND_A_RESET;
      s.const_b       <= long_math_pkg::CONST_B_RESET;
      s.result        <= long_math_pkg::RESULT_RESET;
      s.trig_prev     <= 1'b0;
      s.phase         <= long_math_pkg::PH_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign prdata          = s.rdata;
  assign long_result_out = s.result;
  assign operand_a_out   = s.operand_a;
  assign result_strobe   = s.result_strobe;

endmodule // long_math_unit

/* File: testbench/scan_controller_model.sv */
// Controller model: one scan tick per request, with operand B and the trigger.
// Assumes the bench pulses fire for exactly one cycle per scan.
`timescale 1ns/1ps
module scan_controller_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        fire,
  input  wire logic [31:0] b_value,
  input  wire logic        trig_value,
  output logic             scan_tick,
  output logic [31:0]      operand_b,
  output logic             trigger_in
);
  // Operand B toggles outside the scan cycle, so a stale sample cannot pass by luck.
  // Operand A is the unit's own writable register; this side supplies only B.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_tick  <= 1'b0;
      operand_b  <= 32'h0;
      trigger_in <= 1'b0;
    end else begin
      scan_tick  <= fire;
      operand_b  <= fire ? b_value : ~operand_b;
      trigger_in <= trig_value;
    end
  end
endmodule // scan_controller_model

/* File: testbench/long_math_unit_sva.sv */
// Checker for the long math unit, bound to its ports.
// Assumes control is not rewritten while an evaluation is in flight.
`timescale 1ns/1ps
module long_math_unit_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] operand_b,
  input wire logic        trigger_in,
  input wire logic        scan_tick,
  input wire logic [31:0] long_result_out,
  input wire logic [31:0] operand_a_out,
  input wire logic        result_strobe
);
  logic [10:0] ctrl;
  logic [31:0] cbv;
  logic        tprev;
  logic [5:0]  dcnt;
  logic [31:0] bsel;
  logic [4:0]  op;
  logic        eval;
  logic        rise;
  logic        plain;
  logic        wr;
  assign wr    = psel && penable && pwrite;
  assign op    = ctrl[4:0];
  assign bsel  = ctrl[10] ? cbv : operand_b;
  assign eval  = scan_tick && !ctrl[8] && dcnt == 6'h0;
  assign rise  = scan_tick && ctrl[8] && trigger_in && !tprev && dcnt == 6'h0;
  assign plain = op inside {[5'h00:5'h08], [5'h0f:5'h11]} && op != 5'h03;
  function automatic logic [31:0] ref_op(input logic [4:0] o, input logic [31:0] a, input logic [31:0] b);
    case (o)
      5'h00: return a + b;
      5'h01: return a - b;
      5'h02: return a * b;
      5'h04: return a & b;
      5'h05: return a | b;
      5'h06: return a ^ b;
      5'h07: return a << b;
      5'h08: return a >> b;
      5'h0f: return ($signed(b) > $signed(a)) ? b : a;
      5'h10: return ($signed(b) < $signed(a)) ? b : a;
      default: return a + (b << 8);
    endcase
  endfunction
  // A divide keeps the unit deaf to scans, so dcnt mirrors that window.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl  <= 11'h0;
      cbv   <= 32'h0;
      tprev <= 1'b0;
      dcnt  <= 6'h0;
    end else begin
      if (wr && paddr == long_math_pkg::OFF_CONTROL) ctrl <= pwdata[10:0];
      if (wr && paddr == long_math_pkg::OFF_CONST_B) cbv <= pwdata;
      if (scan_tick) tprev <= trigger_in;
      if (dcnt != 6'h0) dcnt <= dcnt - 6'h1;
      else if ((eval || rise) && op == 5'h03 && bsel != 32'h0) dcnt <= 6'h21;
    end
  end
  default clocking dclk @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_alu;
    eval && plain |=> result_strobe && long_result_out == ref_op($past(op), $past(operand_a_out), $past(bsel));
  endproperty
  a_alu: assert property (p_alu)
    else $error("plain operation result wrong");
  property p_rise;
    rise && plain |=> result_strobe;
  endproperty
  a_rise: assert property (p_rise)
    else $error("trigger rise not evaluated");
  property p_quiet;
    ctrl[8] && !rise && dcnt == 6'h0 |=> !result_strobe;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("evaluation without trigger rise");
  property p_wb;
    result_strobe && ctrl[9] |-> operand_a_out == long_result_out;
  endproperty
  a_wb: assert property (p_wb)
    else $error("write-back target differs from result");
  property p_div;
    eval && op == 5'h03 && bsel != 32'h0 |=> !result_strobe[*8] ##26 result_strobe;
  endproperty
  a_div: assert property (p_div)
    else $error("divide result timing wrong");
  property p_divz;
    eval && op == 5'h03 && bsel == 32'h0 |=>
      (!result_strobe && $stable(long_result_out) && $stable(operand_a_out))[*4];
  endproperty
  a_divz: assert property (p_divz)
    else $error("divide by zero changed state");
  property p_chk;
    eval && op == 5'h09 && bsel < 32'h10 |=> result_strobe
      && long_result_out == {31'h0, $past(operand_a_out[bsel[3:0]])};
  endproperty
  a_chk: assert property (p_chk)
    else $error("bit check result wrong");
  property p_chk_range;
    eval && op == 5'h09 && bsel > 32'hf |=> !result_strobe;
  endproperty
  a_chk_range: assert property (p_chk_range)
    else $error("bit check out of range evaluated");
  c_div: cover property (eval && op == 5'h03 && bsel != 32'h0);
  c_wb: cover property (result_strobe && ctrl[9]);
  c_rise: cover property (rise);
endmodule // long_math_unit_sva

bind long_math_unit long_math_unit_sva u_sva (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
  .operand_b, .trigger_in, .scan_tick, .long_result_out, .operand_a_out, .result_strobe);

/* File: testbench/long_math_unit_tb.sv */
// Self-checking bench for the long math unit over APB and scan ticks.
// Assumes the controller model supplies scans, operand B and the trigger.
`timescale 1ns/1ps
module long_math_unit_tb;
  typedef struct packed {
    logic [4:0]  op;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] exp;
    logic        stb;
  } row_t;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] operand_b;
  logic        trigger_in;
  logic        scan_tick;
  logic [31:0] long_result_out;
  logic [31:0] operand_a_out;
  logic        result_strobe;
  logic        fire;
  logic [31:0] b_value;
  logic        trig_value;
  logic [31:0] q;
  logic        e;
  logic        s;
  int          error_cnt;
  int          tests_run;
  row_t        rows [21] = '{
    '{5'h00, 32'h7ffffffe, 32'h3, 32'h80000001, 1'b1},
    '{5'h01, 32'h7ffffffe, 32'h3, 32'h7ffffffb, 1'b1},
    '{5'h02, 32'h7ffffffe, 32'h3, 32'h7ffffffa, 1'b1},
    '{5'h04, 32'h7ffffffe, 32'h3, 32'h00000002, 1'b1},
    '{5'h05, 32'h7ffffffe, 32'h3, 32'h7fffffff, 1'b1},
    '{5'h06, 32'h7ffffffe, 32'h3, 32'h7ffffffd, 1'b1},
    '{5'h07, 32'h7ffffffe, 32'h3, 32'hfffffff0, 1'b1},
    '{5'h08, 32'h7ffffffe, 32'h3, 32'h0fffffff, 1'b1},
    '{5'h0f, 32'hfffffffb, 32'h8, 32'h00000008, 1'b1},
    '{5'h10, 32'hfffffffb, 32'hfffffff0, 32'hfffffff0, 1'b1},
    '{5'h07, 32'h1, 32'h20, 32'h0, 1'b1},
    '{5'h09, 32'he, 32'h2, 32'h1, 1'b1},
    '{5'h09, 32'h8000, 32'h10, 32'h0, 1'b0},
    '{5'h0e, 32'h5, 32'h1, 32'h0, 1'b0},
    '{5'h14, 32'h5, 32'h1, 32'h0, 1'b0},
    '{5'h11, 32'h7ffffffe, 32'h3, 32'h800002fe, 1'b1},
    '{5'h12, 32'h8001, 32'h0, 32'hffff8001, 1'b1},
    '{5'h0a, 32'h3, 32'h1, 32'h6, 1'b1},
    '{5'h0b, 32'h3, 32'h1, 32'h1, 1'b1},
    '{5'h0c, 32'h8000, 32'h4, 32'h80000, 1'b1},
    '{5'h0d, 32'h8000, 32'h4, 32'h800, 1'b1}};

  long_math_unit u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .operand_b, .trigger_in, .scan_tick, .long_result_out, .operand_a_out, .result_strobe);
  scan_controller_model u_ctl (.pclk, .presetn, .fire, .b_value, .trig_value, .scan_tick, .operand_b,
    .trigger_in);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // The unit takes the scan two edges after the request; s is the strobe in the cycle after it.
  task automatic scan(input logic [31:0] b, input logic t);
    b_value    <= b;
    trig_value <= t;
    fire       <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
    s = result_strobe;
    @(posedge pclk);
  endtask

  task automatic reset_dut();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  task automatic t_reset();
    check(long_result_out | operand_a_out, 32'h0);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check(q, 32'h0);
    end
    apb(1'b0, 8'h14, 32'h0);
    check({31'h0, e}, 32'h1);
    $display("test reset done");
  endtask

  task automatic t_ops();
    logic [31:0] last;
    last = long_result_out;
    foreach (rows[i]) begin
      apb(1'b1, long_math_pkg::OFF_CONTROL, {27'h0, rows[i].op});
      apb(1'b1, long_math_pkg::OFF_OPERAND_A, rows[i].a);
      scan(rows[i].b, 1'b0);
      if (rows[i].stb) last = rows[i].exp;
      check({31'h0, s}, {31'h0, rows[i].stb});
      check(long_result_out, last);
    end
    $display("test ops done");
  endtask

  task automatic t_div();
    int n;
    apb(1'b1, long_math_pkg::OFF_CONTROL, 32'h203);
    apb(1'b1, long_math_pkg::OFF_OPERAND_A, 32'hffffff9c);
    scan(32'h7, 1'b0);
    scan(32'h7, 1'b0);
    // The second scan lands mid-divide; n counts edges from the first scan's taken edge.
    n = 4;
    @(negedge pclk);
    while (result_strobe !== 1'b1 && n < 60) begin
      @(negedge pclk);
      n++;
    end
    check(32'(n), 32'h21);
    check(operand_a_out, 32'hfffffff2);
    @(posedge pclk);
    scan(32'h0, 1'b0);
    repeat (8) @(posedge pclk);
    check({31'h0, s}, 32'h0);
    check(long_result_out & operand_a_out, 32'hfffffff2);
    apb(1'b0, long_math_pkg::OFF_STATUS, 32'h0);
    check(q, 32'he);
    apb(1'b1, long_math_pkg::OFF_STATUS, 32'hc);
    apb(1'b0, long_math_pkg::OFF_STATUS, 32'h0);
    check(q, 32'h2);
    $display("test divide done");
  endtask

  task automatic t_wb();
    apb(1'b1, long_math_pkg::OFF_CONTROL, 32'h600);
    apb(1'b1, long_math_pkg::OFF_CONST_B, 32'h5);
    apb(1'b1, long_math_pkg::OFF_OPERAND_A, 32'ha);
    scan(32'h1234, 1'b0);
    check(operand_a_out, 32'hf);
    scan(32'h1234, 1'b0);
    apb(1'b0, long_math_pkg::OFF_OPERAND_A, 32'h0);
    check(q, 32'h14);
    $display("test write-back done");
  endtask

  task automatic t_edge();
    logic [4:0] trig;
    logic [4:0] want;
    trig = 5'b10110;
    want = 5'b10010;
    apb(1'b1, long_math_pkg::OFF_CONTROL, 32'h700);
    apb(1'b0, long_math_pkg::OFF_CONTROL, 32'h0);
    check(q, 32'h700);
    apb(1'b1, long_math_pkg::OFF_CONST_B, 32'h1);
    apb(1'b1, long_math_pkg::OFF_OPERAND_A, 32'h0);
    for (int i = 0; i < 5; i++) begin
      scan(32'h0, trig[i]);
      check({31'h0, s}, {31'h0, want[i]});
    end
    check(operand_a_out, 32'h2);
    reset_dut();
    apb(1'b1, long_math_pkg::OFF_CONTROL, 32'h100);
    scan(32'h3, 1'b1);
    check(long_result_out, 32'h3);
    $display("test edge trigger done");
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h0;
    pwdata     = 32'h0;
    fire       = 1'b0;
    b_value    = 32'h0;
    trig_value = 1'b0;
    error_cnt  = 0;
    tests_run  = 0;
    reset_dut();
    t_reset();
    t_ops();
    t_div();
    t_wb();
    t_edge();
    report_and_stop();
  end
endmodule // long_math_unit_tb
